// [common/rmc_pkg.sv]
// Package: register map and field layout of the radio modem configuration bank
package rmc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [9:0] OFF_RATE_LOW = 10'h10c;
  localparam logic [9:0] OFF_DEV_RATE_HIGH = 10'h10d;
  localparam logic [9:0] OFF_DEV_LOW = 10'h10e;
  localparam logic [9:0] OFF_CORR_BW = 10'h10f;
  localparam logic [9:0] OFF_POSTDEMOD = 10'h110;
  localparam logic [9:0] OFF_RSVD = 10'h111;
  localparam logic [9:0] OFF_PLL_PHASE = 10'h112;
  localparam logic [9:0] OFF_LOOP_CTRL = 10'h113;
  // Field positions
  localparam int RATE_HI_LSB = 0;
  localparam int DEV_HI_LSB = 4;
  localparam int PHASE_LSB = 0;
  localparam int PLL_LSB = 2;
  localparam int LOOP_SEL_LSB = 4;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_POSTDEMOD = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Scale factors
  localparam int RATE_STEP_BPS = 100;
  localparam int POSTDEMOD_STEP_KHZ = 2;
  // Loop table modes
  localparam logic [1:0] LOOP_SEL_PREDEF = 2'h0;
  localparam logic [1:0] LOOP_SEL_CUSTOM_A = 2'h1;
  localparam logic [1:0] LOOP_SEL_CUSTOM_B = 2'h3;
  typedef enum logic [1:0] {
    RMC_IDLE = 2'b01,
    RMC_ACTIVE = 2'b10
  } rmc_radio_type;
endpackage

// [design/rmc_config_regs.sv]
// Design: byte-wide configuration register bank of the FSK radio modem
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module rmc_config_regs (
  input wire logic i_core_clk, // 25 MHz clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [rmc_pkg::ADDR_W-1:0] i_addr, // Register address
  input wire logic [rmc_pkg::DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic i_tx_req, // Request transmit state
  input wire logic i_rx_req, // Request receive state
  input wire logic i_idle_req, // Return to idle
  output logic [rmc_pkg::DATA_W-1:0] o_rdata, // Read data
  output logic [11:0] o_rate_code, // Bit-rate code
  output logic [18:0] o_rate_bps, // Bit rate in bps
  output logic [11:0] o_tone_offset_code, // Deviation code
  output logic [7:0] o_correlator_bw_code, // Correlator bandwidth
  output logic [1:0] o_correlator_phase_code, // Correlator phase
  output logic [8:0] o_postdemod_bw_khz, // Post-demod bandwidth kHz
  output logic o_postdemod_code_bad, // Filter code zero
  output logic [5:0] o_rx_pll_bw, // Applied PLL setting
  output logic [1:0] o_loop_table_select, // Loop table mode
  output logic o_load_tables, // Predefined table load pulse
  output logic o_transmit_state, // In transmit state
  output logic o_receive_state // In receive state
);
  import rmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] rate_low;
  logic [7:0] deviation_rate_high;
  logic [7:0] deviation_low;
  logic [7:0] correlator_bandwidth;
  logic [7:0] postdemod_filter_bw;
  logic [7:0] reserved_zero_byte;
  logic [7:0] rx_pll_and_corr_phase;
  logic [7:0] loop_ctrl;
  logic [1:0] loop_table_select;
  logic [5:0] rx_pll_bw_setting;
  logic [11:0] rate_code;
  logic [7:0] next_rdata;
  rmc_radio_type radio_state;
  rmc_radio_type next_radio_state;
  logic entering;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rate_low <= RST_BYTE;
      deviation_rate_high <= RST_BYTE;
      deviation_low <= RST_BYTE;
      correlator_bandwidth <= RST_BYTE;
      postdemod_filter_bw <= RST_POSTDEMOD;
      reserved_zero_byte <= RST_BYTE;
      rx_pll_and_corr_phase <= RST_BYTE;
      loop_ctrl <= RST_BYTE;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        OFF_RATE_LOW: rate_low <= i_wdata;
        OFF_DEV_RATE_HIGH: deviation_rate_high <= i_wdata;
        OFF_DEV_LOW: deviation_low <= i_wdata;
        OFF_CORR_BW: correlator_bandwidth <= i_wdata;
        OFF_POSTDEMOD: postdemod_filter_bw <= i_wdata;
        // Reserved byte is plain storage, software keeps it zero
        OFF_RSVD: reserved_zero_byte <= i_wdata;
        OFF_PLL_PHASE: rx_pll_and_corr_phase <= i_wdata;
        OFF_LOOP_CTRL: loop_ctrl <= i_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read
  always_comb begin
    case (i_addr)
      OFF_RATE_LOW: next_rdata = rate_low;
      OFF_DEV_RATE_HIGH: next_rdata = deviation_rate_high;
      OFF_DEV_LOW: next_rdata = deviation_low;
      OFF_CORR_BW: next_rdata = correlator_bandwidth;
      OFF_POSTDEMOD: next_rdata = postdemod_filter_bw;
      OFF_RSVD: next_rdata = reserved_zero_byte;
      OFF_PLL_PHASE: next_rdata = rx_pll_and_corr_phase;
      OFF_LOOP_CTRL: next_rdata = loop_ctrl;
      default: next_rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= RST_BYTE;
    end else if (i_ce && i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign loop_table_select = loop_ctrl[LOOP_SEL_LSB +: 2];
  assign rx_pll_bw_setting = rx_pll_and_corr_phase[PLL_LSB +: 6];
  assign rate_code = {deviation_rate_high[RATE_HI_LSB +: 4], rate_low};

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rate_code <= 12'h000;
      o_rate_bps <= 19'h00000;
      o_tone_offset_code <= 12'h000;
      o_correlator_bw_code <= RST_BYTE;
      o_correlator_phase_code <= 2'h0;
      o_postdemod_bw_khz <= 9'(RST_POSTDEMOD * POSTDEMOD_STEP_KHZ);
      o_postdemod_code_bad <= 1'b0;
      o_rx_pll_bw <= 6'h00;
      o_loop_table_select <= LOOP_SEL_PREDEF;
    end else if (i_ce) begin
      o_rate_code <= rate_code;
      o_rate_bps <= 19'(rate_code * RATE_STEP_BPS);
      o_tone_offset_code <= {deviation_rate_high[DEV_HI_LSB +: 4], deviation_low};
      o_correlator_bw_code <= correlator_bandwidth;
      o_correlator_phase_code <= rx_pll_and_corr_phase[PHASE_LSB +: 2];
      o_postdemod_bw_khz <= 9'(postdemod_filter_bw * POSTDEMOD_STEP_KHZ);
      o_postdemod_code_bad <= (postdemod_filter_bw == 8'h00);
      // Modes 0 and 2 force the applied setting to zero
      if (loop_table_select == LOOP_SEL_CUSTOM_A || loop_table_select == LOOP_SEL_CUSTOM_B) begin
        o_rx_pll_bw <= rx_pll_bw_setting;
      end else begin
        o_rx_pll_bw <= 6'h00;
      end
      o_loop_table_select <= loop_table_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Radio state and table load
  always_comb begin
    case (radio_state)
      RMC_IDLE: next_radio_state = entering ? RMC_ACTIVE : RMC_IDLE;
      RMC_ACTIVE: next_radio_state = i_idle_req ? RMC_IDLE : RMC_ACTIVE;
      default: next_radio_state = RMC_IDLE;
    endcase
  end

  assign entering = (i_tx_req || i_rx_req) && !i_idle_req;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      radio_state <= RMC_IDLE;
      o_transmit_state <= 1'b0;
      o_receive_state <= 1'b0;
      o_load_tables <= 1'b0;
    end else if (i_ce) begin
      radio_state <= next_radio_state;
      if (i_idle_req) begin
        o_transmit_state <= 1'b0;
        o_receive_state <= 1'b0;
      end else if (i_tx_req) begin
        o_transmit_state <= 1'b1;
        o_receive_state <= 1'b0;
      end else if (i_rx_req) begin
        o_transmit_state <= 1'b0;
        o_receive_state <= 1'b1;
      end
      // Pulse on each entry into transmit or receive while the loop table mode is predefined (0)
      o_load_tables <= entering && (loop_table_select == LOOP_SEL_PREDEF)
        && !(i_tx_req && o_transmit_state) && !(!i_tx_req && o_receive_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_readback;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_wr) ##1 (i_ce && i_rd && !i_wr && i_addr == $past(i_addr)
        && i_addr >= OFF_RATE_LOW && i_addr <= OFF_LOOP_CTRL)
      |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_rate_bps;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_ce |=> o_rate_bps == 19'($past(rate_code) * RATE_STEP_BPS);
  endproperty
  a_rate_bps: assert property (p_rate_bps) else $error("rate bps wrong");

  property p_rate_code;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_wr && i_addr == OFF_DEV_RATE_HIGH) ##1 i_ce
      |=> o_rate_code[11:8] == $past(i_wdata[3:0], 2);
  endproperty
  a_rate_code: assert property (p_rate_code) else $error("rate high nibble wrong");

  property p_dev_high;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_wr && i_addr == OFF_DEV_RATE_HIGH) ##1 i_ce
      |=> o_tone_offset_code[11:8] == $past(i_wdata[7:4], 2);
  endproperty
  a_dev_high: assert property (p_dev_high) else $error("deviation high wrong");

  property p_dev_low;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_wr && i_addr == OFF_DEV_LOW) ##1 i_ce
      |=> o_tone_offset_code[7:0] == $past(i_wdata, 2);
  endproperty
  a_dev_low: assert property (p_dev_low) else $error("deviation low wrong");

  property p_postdemod;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_ce |=> o_postdemod_bw_khz == {$past(postdemod_filter_bw), 1'b0};
  endproperty
  a_postdemod: assert property (p_postdemod) else $error("filter bandwidth wrong");

  property p_corr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_ce |=> o_correlator_bw_code == $past(correlator_bandwidth)
        && o_correlator_phase_code == $past(rx_pll_and_corr_phase[1:0]);
  endproperty
  a_corr: assert property (p_corr) else $error("correlator fields wrong");

  property p_pll;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !loop_table_select[0]) |=> o_rx_pll_bw == 6'h00;
  endproperty
  a_pll: assert property (p_pll) else $error("pll setting applied in mode 0 or 2");

  property p_load;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ($past(i_ce) && o_load_tables)
      |-> $past(loop_table_select) == LOOP_SEL_PREDEF && $past(entering);
  endproperty
  a_load: assert property (p_load) else $error("table load without cause");

  // Clock enable and bus side
  property p_freeze;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_ce |=> $stable(o_rdata) && $stable(o_rate_code) && $stable(o_tone_offset_code)
        && $stable(o_rx_pll_bw) && $stable(o_load_tables)
        && $stable(o_transmit_state) && $stable(o_receive_state);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_rdata_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !i_rd) |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_unmapped;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_rd && (i_addr < OFF_RATE_LOW || i_addr > OFF_LOOP_CTRL))
      |=> o_rdata == UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_code_bad;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_ce |=> o_postdemod_code_bad == ($past(postdemod_filter_bw) == 8'h00);
  endproperty
  a_code_bad: assert property (p_code_bad) else $error("filter code flag wrong");

  // Radio state
  property p_tx_entry;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_tx_req && !i_idle_req) |=> o_transmit_state && !o_receive_state;
  endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("transmit state not entered");

  property p_load_due;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && entering && loop_table_select == LOOP_SEL_PREDEF
        && (i_tx_req ? !o_transmit_state : !o_receive_state)) |=> o_load_tables;
  endproperty
  a_load_due: assert property (p_load_due) else $error("table load missing on entry");

  property p_state_excl;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !(o_transmit_state && o_receive_state);
  endproperty
  a_state_excl: assert property (p_state_excl) else $error("transmit and receive both set");

  property p_state_track;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (radio_state == RMC_ACTIVE) == (o_transmit_state || o_receive_state);
  endproperty
  a_state_track: assert property (p_state_track) else $error("radio state out of step");

  c_tx_load: cover property (@(posedge i_core_clk) o_load_tables && o_transmit_state);
  c_rx_load: cover property (@(posedge i_core_clk) o_load_tables && o_receive_state);
  c_pll: cover property (@(posedge i_core_clk) o_rx_pll_bw != 6'h00);
  c_read: cover property (@(posedge i_core_clk) i_wr ##1 i_rd);
  c_custom_b: cover property (@(posedge i_core_clk) o_loop_table_select == LOOP_SEL_CUSTOM_B);
endmodule

// [tb/rmc_config_regs_tb_top.sv]
// Testbench: self-checking scenarios for the radio modem configuration bank
`timescale 1ns/1ns
module rmc_config_regs_tb_top;
  import rmc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic [9:0] i_addr = 10'h000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_tx_req = 1'b0;
  logic i_rx_req = 1'b0;
  logic i_idle_req = 1'b0;
  logic [7:0] o_rdata, o_correlator_bw_code;
  logic [11:0] o_rate_code, o_tone_offset_code;
  logic [18:0] o_rate_bps;
  logic [1:0] o_correlator_phase_code, o_loop_table_select;
  logic [8:0] o_postdemod_bw_khz;
  logic [5:0] o_rx_pll_bw;
  logic o_postdemod_code_bad, o_load_tables, o_transmit_state, o_receive_state;
  logic [7:0] vals [8] = '{8'h3c, 8'h9a, 8'h5e, 8'hc7, 8'h62, 8'h00, 8'h02, 8'h10};
  localparam logic [7:0] PLL_VAL = 8'hb6;
  logic [7:0] d;
  int n_mismatch = 0;
  int compares = 0;
  always #20 i_core_clk = ~i_core_clk;
  rmc_config_regs i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tx_req(i_tx_req),
    .i_rx_req(i_rx_req), .i_idle_req(i_idle_req), .o_rdata(o_rdata),
    .o_rate_code(o_rate_code), .o_rate_bps(o_rate_bps),
    .o_tone_offset_code(o_tone_offset_code), .o_correlator_bw_code(o_correlator_bw_code),
    .o_correlator_phase_code(o_correlator_phase_code),
    .o_postdemod_bw_khz(o_postdemod_bw_khz), .o_postdemod_code_bad(o_postdemod_code_bad),
    .o_rx_pll_bw(o_rx_pll_bw), .o_loop_table_select(o_loop_table_select),
    .o_load_tables(o_load_tables), .o_transmit_state(o_transmit_state),
    .o_receive_state(o_receive_state));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    v = o_rdata;
  endtask
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] v, output logic [7:0] q);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    q = o_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  // Kind 0 transmit, 1 receive, 2 idle; counts load pulses after the request
  task automatic req(input int kind, input int pulses);
    int n;
    logic [18:0] exp_state;
    n = 0;
    exp_state = (kind == 0) ? 19'h2 : (kind == 1) ? 19'h1 : 19'h0;
    @(posedge i_core_clk);
    i_tx_req <= (kind == 0);
    i_rx_req <= (kind == 1);
    i_idle_req <= (kind == 2);
    @(posedge i_core_clk);
    i_tx_req <= 1'b0;
    i_rx_req <= 1'b0;
    i_idle_req <= 1'b0;
    repeat (4) begin
      @(negedge i_core_clk);
      if (o_load_tables === 1'b1) n++;
    end
    cmp(19'(n), 19'(pulses));
    cmp(19'({o_transmit_state, o_receive_state}), exp_state);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(OFF_RATE_LOW + 10'(i), d);
      if (OFF_RATE_LOW + 10'(i) == OFF_POSTDEMOD) cmp(19'(d), 19'(RST_POSTDEMOD));
      else cmp(19'(d), 19'(RST_BYTE));
    end
    cmp(19'(o_postdemod_bw_khz), 19'(RST_POSTDEMOD) * 19'(POSTDEMOD_STEP_KHZ));
    cmp(19'({o_postdemod_code_bad, o_load_tables, o_transmit_state, o_receive_state}), 19'h0);
  endtask
  task automatic t_fields();
    for (int i = 0; i < 8; i++) begin
      wr_rd(OFF_RATE_LOW + 10'(i), vals[i], d);
      cmp(19'(d), 19'(vals[i]));
    end
    cmp(19'(o_rate_code), 19'({vals[1][3:0], vals[0]}));
    cmp(o_rate_bps, 19'({vals[1][3:0], vals[0]}) * 19'(RATE_STEP_BPS));
    cmp(19'(o_tone_offset_code), 19'({vals[1][7:4], vals[2]}));
    cmp(19'(o_tone_offset_code[7:0]), 19'(vals[2]));
    cmp(19'(o_correlator_bw_code), 19'(vals[3]));
    cmp(19'(o_correlator_phase_code), 19'(vals[6][1:0]));
    cmp(19'(o_postdemod_bw_khz), 19'(vals[4]) * 19'(POSTDEMOD_STEP_KHZ));
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      if (m[0]) begin
        wr(OFF_LOOP_CTRL, 8'(m << LOOP_SEL_LSB));
        wr(OFF_PLL_PHASE, PLL_VAL);
      end else begin
        wr(OFF_PLL_PHASE, vals[6]);
        wr(OFF_LOOP_CTRL, 8'(m << LOOP_SEL_LSB));
      end
      settle();
      cmp(19'(o_loop_table_select), 19'(m));
      cmp(19'(o_rx_pll_bw), m[0] ? 19'(PLL_VAL[7:2]) : 19'h0);
    end
    wr(OFF_POSTDEMOD, 8'h00);
    settle();
    cmp(19'(o_postdemod_code_bad), 19'h1);
    wr(OFF_POSTDEMOD, 8'h01);
    settle();
    cmp(19'({o_postdemod_code_bad, o_postdemod_bw_khz}), 19'h002);
    wr(OFF_POSTDEMOD, 8'hff);
    settle();
    cmp(19'(o_postdemod_bw_khz), 19'h1fe);
  endtask
  task automatic t_refuse();
    wr(10'h114, 8'ha5);
    rd(10'h114, d);
    cmp(19'(d), 19'(UNMAPPED_READ));
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= OFF_CORR_BW;
    i_wdata <= 8'h11;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    i_ce <= 1'b1;
    @(negedge i_core_clk);
    cmp(19'(o_rdata), 19'(UNMAPPED_READ));
    rd(OFF_CORR_BW, d);
    cmp(19'(d), 19'(vals[3]));
  endtask
  task automatic t_radio();
    wr(OFF_PLL_PHASE, vals[6]);
    wr(OFF_LOOP_CTRL, 8'h00);
    req(0, 1);
    req(0, 0);
    req(1, 1);
    req(2, 0);
    wr(OFF_LOOP_CTRL, 8'h10);
    req(1, 0);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_modes();
    t_refuse();
    t_radio();
    stop_test();
  end
endmodule
